// *** core/pin_sync.sv ***
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module pin_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst_n,
	// Pins
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] level
);
	logic [W-1:0] meta_q;
	logic [W-1:0] level_q;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q  <= '0;
			level_q <= '0;
		end else begin
			meta_q  <= pin;
			level_q <= meta_q;
		end
	end

	assign level = level_q;
endmodule

// *** core/pwm_core_defines.svh ***
// Purpose: Register offsets, field positions and constants of the PWM control core.
// Assumes: 32-bit APB data, one aligned word per register.
// Notes: Field macros are bit ranges, used as vec[`FIELD].
`ifndef PWM_CORE_DEFINES_SVH
`define PWM_CORE_DEFINES_SVH

`define ADDR_W          8
`define NUM_CH          8
`define OFS_CTRL        8'h00
`define OFS_MODULO      8'h04
`define OFS_INIT        8'h08
`define OFS_HALF        8'h0C
`define OFS_TRIG_SEL    8'h10
`define OFS_RELOAD_SEL  8'h14
`define OFS_INT_EN      8'h18
`define OFS_STATUS      8'h1C
`define OFS_COUNT       8'h20
`define OFS_SAFE        8'h24
`define CMP_PAGE        3'h2
`define ADDR_PAGE       7:5
`define ADDR_CH         4:2

`define CTRL_HALT       1:0
`define CTRL_FAULT      3:2
`define CTRL_UPDOWN     4
`define CTRL_EN         5
`define CTRL_SW_SYNC    6
`define CTRL_HW_SYNC_EN 9:7
`define CTRL_SW_SYNC_EN 10
`define CTRL_FAULT_CLR  11
`define CTRL_W          12
`define CTRL_PULSE_MASK 12'h840

`define SEL_INIT        8
`define SEL_RELOAD      9
`define SEL_W           10
`define RL_MAX          8
`define RL_MIN          9
`define RL_HALF         10
`define RL_W            11
`define IE_FAULT        8
`define IE_OVF          9
`define IE_RELOAD       10
`define IE_W            11
`define ST_FAULT        8
`define ST_OVF          9
`define ST_TRIG         10
`define ST_RELOAD       11
`define ST_W            12

`define EVEN_CH_MASK    8'h55
`define ALL_CH_MASK     8'hFF
`define HW_SYNC_N       3

`endif

// *** core/pwm_core_pkg.sv ***
// Purpose: Types shared by the PWM control core.
// Assumes: Codes match the two-bit control fields.
// Notes: None.
package pwm_core_pkg;
	typedef enum logic [1:0] {
		halt_stop_live_setting      = 2'b00,
		halt_stop_safe_setting      = 2'b01,
		halt_freeze_outputs_setting = 2'b10,
		halt_keep_running_setting   = 2'b11
	} halt_setting_t;
	typedef enum logic [1:0] {
		fault_off_mode                = 2'b00,
		even_channel_fault_mode       = 2'b01,
		all_channel_manual_fault_mode = 2'b10,
		all_channel_auto_fault_mode   = 2'b11
	} fault_mode_t;
endpackage

// *** core/pwm_trigger_fault.sv ***
// Purpose: PWM timer core with halt behaviour, fault control, triggers,
//          buffered updates, reload points and status flags over APB.
// Assumes: Synchronous APB master on CLK; pins are asynchronous.
// Notes: Waveform is a simple edge-aligned high-true pulse per channel.
`timescale 1ns/1ns
`include "pwm_core_defines.svh"
module pwm_trigger_fault #(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// APB slave
	input  wire logic                PSEL,
	input  wire logic                PENABLE,
	input  wire logic                PWRITE,
	input  wire logic [`ADDR_W-1:0]  PADDR,
	input  wire logic [31:0]         PWDATA,
	output logic      [31:0]         PRDATA,
	output logic                     PREADY,
	output logic                     PSLVERR,
	// Asynchronous pins
	input  wire logic                HALT_REQ,
	input  wire logic                FAULT_IN,
	input  wire logic [`HW_SYNC_N-1:0] HW_SYNC_IN,
	// Outputs
	output logic      [`NUM_CH-1:0]  CH_OUT,
	output logic                     TRIG_OUT,
	output logic                     IRQ
);
	localparam int N = `NUM_CH;

	logic [31:0]            prdata_q, prdata_d, rd_mux;
	logic                   pready_q, pready_d, pslverr_q, pslverr_d, hit;
	logic [`CTRL_W-1:0]     ctrl_q, ctrl_d;
	logic [`SEL_W-1:0]      tsel_q, tsel_d;
	logic [`RL_W-1:0]       rsel_q, rsel_d;
	logic [`IE_W-1:0]       ien_q, ien_d;
	logic [`ST_W-1:0]       flag_q, flag_d, flag_set, flag_clr;
	logic [N-1:0]           safe_q, safe_d, out_q, out_d, wave_q, wave_d;
	logic [CW-1:0]          mod_b_q, mod_b_d, mod_q, mod_d;
	logic [CW-1:0]          ini_b_q, ini_b_d, ini_q, ini_d;
	logic [CW-1:0]          half_b_q, half_b_d, half_q, half_d;
	logic [CW-1:0]          cmp_b_q [N], cmp_b_d [N], cmp_q [N], cmp_d [N];
	logic [CW-1:0]          cnt_q, cnt_d;
	logic                   up_q, up_d, tick_q, tick_d, en_q, en_d;
	logic                   trig_q, trig_d, irq_q, irq_d, fault_q, fault_d;
	logic [`HW_SYNC_N-1:0]  hw_q, hw_d;
	logic [N-1:0]           match, prot;
	logic                   halted, fault_s, run, sup, direct, wr, setup;
	logic                   sw_sync, fclr, init_ev, max_ev, min_ev, half_ev, reload, load;
	logic [`HW_SYNC_N-1:0]  hw_s;
	pwm_core_pkg::halt_setting_t hset;
	pwm_core_pkg::fault_mode_t   fmode;

	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	pin_sync #(.W(2 + `HW_SYNC_N)) u_sync (
		.clk   (CLK),
		.rst_n (RST_N),
		.pin   ({HALT_REQ, FAULT_IN, HW_SYNC_IN}),
		.level ({halted, fault_s, hw_s})
	);

	// ************************************************************
	// Event decode
	// ************************************************************
	assign hset   = pwm_core_pkg::halt_setting_t'(ctrl_q[`CTRL_HALT]);
	assign fmode  = pwm_core_pkg::fault_mode_t'(ctrl_q[`CTRL_FAULT]);
	assign setup  = PSEL & ~PENABLE;
	assign wr     = PSEL & PENABLE & PWRITE & pready_q;
	// Counter stops in every halt setting except keep-running.
	assign run    = en_q & ~(halted & (hset != pwm_core_pkg::halt_keep_running_setting));
	assign sup    = halted & ((hset == pwm_core_pkg::halt_stop_safe_setting) |
		(hset == pwm_core_pkg::halt_freeze_outputs_setting));
	assign direct = halted & (hset != pwm_core_pkg::halt_keep_running_setting);
	assign sw_sync = wr & (PADDR == `OFS_CTRL) & PWDATA[`CTRL_SW_SYNC] & ctrl_q[`CTRL_SW_SYNC_EN];
	assign fclr   = wr & (PADDR == `OFS_CTRL) & PWDATA[`CTRL_FAULT_CLR];
	// Events only count in the cycle after the counter moved, so a stopped
	// counter resting on a compare value does not retrigger every cycle.
	assign init_ev = tick_q & (cnt_q == ini_q);
	assign max_ev  = tick_q & (cnt_q == mod_q);
	assign min_ev  = init_ev & ctrl_q[`CTRL_UPDOWN];
	assign half_ev = tick_q & (cnt_q == half_q);

	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_ch
			assign match[g] = tick_q & (cnt_q == cmp_q[g]);
		end
	endgenerate

	assign reload = |(match & rsel_q[N-1:0])
		| (ctrl_q[`CTRL_UPDOWN] & max_ev & rsel_q[`RL_MAX])
		| (min_ev & rsel_q[`RL_MIN])
		| (half_ev & rsel_q[`RL_HALF]);
	assign load = reload | sw_sync | (|(hw_s & ~hw_q & ctrl_q[`CTRL_HW_SYNC_EN]));
	assign prot = (fmode == pwm_core_pkg::even_channel_fault_mode) ? `EVEN_CH_MASK
		: `ALL_CH_MASK;

	// ************************************************************
	// Register read decode
	// ************************************************************
	always_comb begin
		rd_mux = 32'h0000_0000;
		hit    = 1'b1;
		if (PADDR[`ADDR_PAGE] == `CMP_PAGE) begin
			rd_mux[CW-1:0] = cmp_b_q[PADDR[`ADDR_CH]];
		end else begin
			case (PADDR)
				`OFS_CTRL:       rd_mux[`CTRL_W-1:0] = ctrl_q;
				`OFS_MODULO:     rd_mux[CW-1:0] = mod_b_q;
				`OFS_INIT:       rd_mux[CW-1:0] = ini_b_q;
				`OFS_HALF:       rd_mux[CW-1:0] = half_b_q;
				`OFS_TRIG_SEL:   rd_mux[`SEL_W-1:0] = tsel_q;
				`OFS_RELOAD_SEL: rd_mux[`RL_W-1:0] = rsel_q;
				`OFS_INT_EN:     rd_mux[`IE_W-1:0] = ien_q;
				`OFS_STATUS:     rd_mux[`ST_W-1:0] = flag_q;
				`OFS_COUNT:      rd_mux[CW-1:0] = cnt_q;
				`OFS_SAFE:       rd_mux[N-1:0] = safe_q;
				default:         hit = 1'b0;
			endcase
		end
	end

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		pready_d  = setup;
		pslverr_d = setup & ~hit;
		prdata_d  = setup ? (PWRITE ? 32'h0000_0000 : rd_mux) : prdata_q;
		ctrl_d  = ctrl_q;
		tsel_d  = tsel_q;
		rsel_d  = rsel_q;
		ien_d   = ien_q;
		safe_d  = safe_q;
		mod_b_d = mod_b_q;
		ini_b_d = ini_b_q;
		half_b_d = half_b_q;
		cmp_b_d = cmp_b_q;
		flag_clr = '0;
		if (wr) begin
			if (PADDR[`ADDR_PAGE] == `CMP_PAGE) begin
				cmp_b_d[PADDR[`ADDR_CH]] = PWDATA[CW-1:0];
			end else begin
				case (PADDR)
					`OFS_CTRL:       ctrl_d = PWDATA[`CTRL_W-1:0] & ~`CTRL_PULSE_MASK;
					`OFS_MODULO:     mod_b_d = PWDATA[CW-1:0];
					`OFS_INIT:       ini_b_d = PWDATA[CW-1:0];
					`OFS_HALF:       half_b_d = PWDATA[CW-1:0];
					`OFS_TRIG_SEL:   tsel_d = PWDATA[`SEL_W-1:0];
					`OFS_RELOAD_SEL: rsel_d = PWDATA[`RL_W-1:0];
					`OFS_INT_EN:     ien_d = PWDATA[`IE_W-1:0];
					`OFS_STATUS:     flag_clr = PWDATA[`ST_W-1:0];
					`OFS_SAFE:       safe_d = PWDATA[N-1:0];
					default:         flag_clr = '0;
				endcase
			end
		end
		// Active copies follow the buffers on a load event, or at once
		// while a halt setting bypasses the buffers.
		mod_d  = (load | direct) ? mod_b_d : mod_q;
		ini_d  = (load | direct) ? ini_b_d : ini_q;
		half_d = (load | direct) ? half_b_d : half_q;
		for (int i = 0; i < N; i++) begin
			cmp_d[i] = (load | direct) ? cmp_b_d[i] : cmp_q[i];
		end

		// Counter.
		en_d   = ctrl_q[`CTRL_EN];
		cnt_d  = cnt_q;
		up_d   = up_q;
		tick_d = 1'b0;
		if (ctrl_q[`CTRL_EN] & ~en_q) begin
			cnt_d  = ini_q;
			up_d   = 1'b1;
			tick_d = 1'b1;
		end else if (run) begin
			tick_d = 1'b1;
			if (!ctrl_q[`CTRL_UPDOWN]) begin
				cnt_d = (cnt_q == mod_q) ? ini_q : cnt_q + 1'b1;
				up_d  = 1'b1;
			end else if (up_q) begin
				up_d  = (cnt_q != mod_q);
				cnt_d = (cnt_q == mod_q) ? cnt_q - 1'b1 : cnt_q + 1'b1;
			end else begin
				up_d  = (cnt_q == ini_q);
				cnt_d = (cnt_q == ini_q) ? cnt_q + 1'b1 : cnt_q - 1'b1;
			end
		end

		// Fault latch: set wins over a software clear.
		if (fmode == pwm_core_pkg::fault_off_mode) begin
			fault_d = 1'b0;
		end else if (fault_s) begin
			fault_d = 1'b1;
		end else if (fmode == pwm_core_pkg::all_channel_auto_fault_mode) begin
			fault_d = 1'b0;
		end else begin
			fault_d = fault_q & ~fclr;
		end

		// Triggers and flags.
		trig_d = |(match & tsel_q[N-1:0])
			| (init_ev & tsel_q[`SEL_INIT])
			| (reload & tsel_q[`SEL_RELOAD]);
		flag_set = '0;
		flag_set[N-1:0]    = sup ? '0 : match;
		flag_set[`ST_FAULT]  = fault_d & ~fault_q;
		flag_set[`ST_OVF]    = max_ev;
		flag_set[`ST_TRIG]   = trig_d;
		flag_set[`ST_RELOAD] = reload;
		flag_d = (flag_q & ~flag_clr) | flag_set;
		irq_d  = |(flag_q[`ST_OVF:0] & ien_q[`IE_OVF:0])
			| (flag_q[`ST_RELOAD] & ien_q[`IE_RELOAD]);
		hw_d   = hw_s;

		// Channel outputs.
		wave_d = wave_q;
		for (int i = 0; i < N; i++) begin
			if (match[i]) begin
				wave_d[i] = 1'b0;
			end else if (init_ev) begin
				wave_d[i] = 1'b1;
			end
		end
		if (halted & (hset == pwm_core_pkg::halt_stop_safe_setting)) begin
			out_d = safe_q;
		end else if (halted & (hset == pwm_core_pkg::halt_freeze_outputs_setting)) begin
			out_d = out_q;
		end else begin
			out_d = fault_q ? ((safe_q & prot) | (wave_q & ~prot)) : wave_q;
		end
	end

	// ************************************************************
	// State registers
	// ************************************************************
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			ctrl_q    <= '0;
			tsel_q    <= '0;
			rsel_q    <= '0;
			ien_q     <= '0;
			flag_q    <= '0;
			safe_q    <= '0;
			mod_b_q   <= '1;
			mod_q     <= '1;
			ini_b_q   <= '0;
			ini_q     <= '0;
			half_b_q  <= '0;
			half_q    <= '0;
			cmp_b_q   <= '{default: '0};
			cmp_q     <= '{default: '0};
			cnt_q     <= '0;
			up_q      <= 1'b1;
			tick_q    <= 1'b0;
			en_q      <= 1'b0;
			trig_q    <= 1'b0;
			irq_q     <= 1'b0;
			fault_q   <= 1'b0;
			hw_q      <= '0;
			wave_q    <= '0;
			out_q     <= '0;
		end else begin
			prdata_q  <= prdata_d;
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			ctrl_q    <= ctrl_d;
			tsel_q    <= tsel_d;
			rsel_q    <= rsel_d;
			ien_q     <= ien_d;
			flag_q    <= flag_d;
			safe_q    <= safe_d;
			mod_b_q   <= mod_b_d;
			mod_q     <= mod_d;
			ini_b_q   <= ini_b_d;
			ini_q     <= ini_d;
			half_b_q  <= half_b_d;
			half_q    <= half_d;
			cmp_b_q   <= cmp_b_d;
			cmp_q     <= cmp_d;
			cnt_q     <= cnt_d;
			up_q      <= up_d;
			tick_q    <= tick_d;
			en_q      <= en_d;
			trig_q    <= trig_d;
			irq_q     <= irq_d;
			fault_q   <= fault_d;
			hw_q      <= hw_d;
			wave_q    <= wave_d;
			out_q     <= out_d;
		end
	end

	assign PRDATA   = prdata_q;
	assign PREADY   = pready_q;
	assign PSLVERR  = pslverr_q;
	assign CH_OUT   = out_q;
	assign TRIG_OUT = trig_q;
	assign IRQ      = irq_q;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_apb_ready_err: assert property (setup |=> PREADY && (PSLVERR == !$past(hit)))
		else $error("APB answer not given one cycle after setup.");
	a_halt_stops_cnt: assert property (direct && !(ctrl_q[`CTRL_EN] && !en_q)
		|=> $stable(cnt_q)) else $error("Counter moved while halted.");
	a_halt_runs_cnt: assert property (halted && !direct && en_q && ctrl_q[`CTRL_EN]
		|=> tick_q) else $error("Counter stopped in run setting.");
	a_halt_no_flags: assert property (sup |=> (flag_q[N-1:0] & ~$past(flag_q[N-1:0])) == '0)
		else $error("Channel flag set while suppressed.");
	a_halt_safe_out: assert property (halted && hset == pwm_core_pkg::halt_stop_safe_setting
		|=> CH_OUT == $past(safe_q)) else $error("Outputs not at safe level.");
	a_halt_hold_out: assert property (
		(halted && hset == pwm_core_pkg::halt_freeze_outputs_setting)[*2] |-> $stable(CH_OUT))
		else $error("Outputs changed while frozen.");
	a_bypass_write: assert property (wr && direct && PADDR == `OFS_MODULO
		|=> mod_q == $past(PWDATA[CW-1:0])) else $error("Direct write not applied.");
	a_buffered_write: assert property (wr && !direct && !load && PADDR == `OFS_MODULO
		|=> $stable(mod_q)) else $error("Buffered write reached active copy.");
	a_fault_ignored: assert property (fmode == pwm_core_pkg::fault_off_mode |=> !fault_q)
		else $error("Fault latched while disabled.");
	a_fault_protect: assert property (fault_q && !halted
		|=> (CH_OUT & $past(prot)) == ($past(safe_q) & $past(prot)))
		else $error("Protected channel not at safe level.");
	a_fault_auto: assert property (fmode == pwm_core_pkg::all_channel_auto_fault_mode
		&& !fault_s ##1 !fault_s |-> !fault_q) else $error("Automatic fault not cleared.");
	a_init_trigger: assert property (init_ev && tsel_q[`SEL_INIT]
		|=> TRIG_OUT && flag_q[`ST_TRIG]) else $error("Initial-load trigger missing.");
	a_irq_gate: assert property ((flag_q[`ST_OVF:0] & ien_q[`IE_OVF:0]) == '0
		&& !(flag_q[`ST_RELOAD] && ien_q[`IE_RELOAD]) |=> !IRQ) else $error("Interrupt not enabled.");
	c_freeze:  cover property (halted && hset == pwm_core_pkg::halt_freeze_outputs_setting);
	c_fault:   cover property (fault_q ##1 !fault_q);
	c_trigger: cover property (TRIG_OUT);
	c_load:    cover property (load && !direct);
endmodule

// *** tb/pwm_far_side.sv ***
// Purpose: Far side of the PWM core: fault pin, sync pins and trigger consumer.
// Assumes: Driven and read from the bench clock domain.
// Notes: Counters are cleared on the falling edge, so they never race the sampling edge.
`timescale 1ns/1ns
module pwm_far_side (
	// Clock
	input  wire logic       clk,
	// Block outputs
	input  wire logic [7:0] ch_out,
	input  wire logic       trig_out,
	// Block inputs
	output logic            fault_pin,
	output logic [2:0]      sync_pin
);
	int         trig_cnt;
	logic [7:0] ch_seen;

	initial begin
		fault_pin = 1'b0;
		sync_pin  = 3'b000;
		trig_cnt  = 0;
		ch_seen   = 8'h00;
	end

	always @(posedge clk) begin
		if (trig_out === 1'b1) begin
			trig_cnt <= trig_cnt + 1;
		end
		ch_seen <= ch_seen | ch_out;
	end

	task automatic clear_seen;
		@(negedge clk);
		trig_cnt = 0;
		ch_seen  = 8'h00;
		@(posedge clk);
	endtask

	task automatic set_fault(input logic v);
		fault_pin <= v;
	endtask

	// The pulse is held for several cycles so the two-flop synchroniser sees it.
	task automatic pulse_sync(input int k);
		sync_pin[k] <= 1'b1;
		repeat (4) @(posedge clk);
		sync_pin[k] <= 1'b0;
	endtask
endmodule

// *** tb/pwm_trigger_fault_test.sv ***
// Purpose: Self-checking bench for the PWM trigger and fault core.
// Assumes: The APB slave answers in its own time; counter period set to sixteen ticks except in t_reload, which shortens it.
// Notes: Every channel compare is 5, so each channel pulses once per period.
`timescale 1ns/1ns
`include "pwm_core_defines.svh"
module pwm_trigger_fault_test;
	logic        clk;
	logic        rst_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        halt_req;
	logic        fault_pin;
	logic [2:0]  sync_pin;
	logic [7:0]  ch_out;
	logic        trig_out;
	logic        irq;
	int          err_count;
	int          n_tests;

	pwm_trigger_fault u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .HALT_REQ(halt_req), .FAULT_IN(fault_pin), .HW_SYNC_IN(sync_pin),
		.CH_OUT(ch_out), .TRIG_OUT(trig_out), .IRQ(irq));
	pwm_far_side u_far (.clk(clk), .ch_out(ch_out), .trig_out(trig_out),
		.fault_pin(fault_pin), .sync_pin(sync_pin));

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic give_verdict;
		if (err_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One idle cycle follows each transfer, so no signal is assigned twice at one edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(1'b1, a, d, r, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		logic e;
		apb(1'b0, a, 32'h0000_0000, d, e);
	endtask

	function automatic logic [31:0] ctrl(input logic [1:0] h, input logic [1:0] f,
			input logic en);
		logic [31:0] v;
		v              = 32'h0000_0000;
		v[`CTRL_HALT]  = h;
		v[`CTRL_FAULT] = f;
		v[`CTRL_EN]    = en;
		return v;
	endfunction

	task automatic see(output logic [31:0] d);
		u_far.clear_seen();
		cyc(40);
		d = {24'h00_0000, u_far.ch_seen};
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs;
		logic [31:0] d;
		logic        e;
		rd(`OFS_MODULO, d);
		check(d, 32'h0000_FFFF);
		rd(`OFS_CTRL, d);
		check(d, 32'h0000_0000);
		apb(1'b0, 8'h28, 32'h0000_0000, d, e);
		check({e, d[30:0]}, 32'h8000_0000);
	endtask

	task automatic t_sync_load;
		logic [31:0] d;
		wr(`OFS_MODULO, 32'h0000_000F);
		for (int i = 0; i < 8; i++) begin
			wr({`CMP_PAGE, i[2:0], 2'b00}, 32'h0000_0005);
		end
		wr(`OFS_CTRL, 32'h0000_0100);
		u_far.pulse_sync(1);
		cyc(8);
		wr(`OFS_CTRL, ctrl(2'd0, 2'd0, 1'b1));
		repeat (8) begin
			rd(`OFS_COUNT, d);
			check(d <= 32'h0000_000F, 32'h1);
			cyc(5);
		end
	endtask

	task automatic t_trigger;
		logic [31:0] d;
		logic [31:0] sel [5] = '{32'h0000_0040, 32'h0000_0004, 32'h0, 32'h0000_0100,
			32'h0000_0200};
		logic        exp [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
		wr(`OFS_RELOAD_SEL, 32'h0000_0001);
		for (int i = 0; i < 5; i++) begin
			wr(`OFS_TRIG_SEL, sel[i]);
			cyc(4);
			u_far.clear_seen();
			cyc(48);
			check(u_far.trig_cnt != 0, exp[i]);
		end
		rd(`OFS_STATUS, d);
		check({d[`ST_RELOAD], d[`ST_TRIG], d[6]}, 3'b111);
	endtask

	task automatic t_irq;
		logic [31:0] en  [4] = '{32'h0, 32'h0000_0040, 32'h0000_0200, 32'h0};
		logic        exp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_INT_EN, en[i]);
			cyc(3);
			check(irq, exp[i]);
		end
	endtask

	task automatic t_fault;
		logic [31:0] d;
		logic [7:0]  on_x  [4] = '{8'hFF, 8'hAA, 8'h00, 8'h00};
		logic [7:0]  off_x [4] = '{8'hFF, 8'hAA, 8'h00, 8'hFF};
		for (int m = 0; m < 4; m++) begin
			wr(`OFS_CTRL, ctrl(2'd0, m[1:0], 1'b1));
			wr(`OFS_STATUS, 32'h0000_0FFF);
			u_far.set_fault(1'b1);
			cyc(6);
			see(d);
			check(d[7:0], on_x[m]);
			rd(`OFS_STATUS, d);
			check(d[`ST_FAULT], m != 0);
			u_far.set_fault(1'b0);
			cyc(6);
			see(d);
			check(d[7:0], off_x[m]);
			wr(`OFS_CTRL, ctrl(2'd0, m[1:0], 1'b1) | 32'h0000_0800);
			cyc(4);
			see(d);
			check(d[7:0], 8'hFF);
		end
	endtask

	// Counter equality is judged only where it must stand still; a running
	// counter may wrap back to the same value between two reads.
	task automatic t_halt;
		logic [31:0] c1;
		logic [31:0] c2;
		logic [31:0] st;
		logic [7:0]  h;
		wr(`OFS_SAFE, 32'h0000_005A);
		for (int s = 0; s < 4; s++) begin
			wr(`OFS_CTRL, ctrl(s[1:0], 2'd0, 1'b1));
			halt_req <= 1'b1;
			cyc(6);
			h = ch_out;
			wr(`OFS_STATUS, 32'h0000_0FFF);
			rd(`OFS_COUNT, c1);
			cyc(30);
			rd(`OFS_COUNT, c2);
			rd(`OFS_STATUS, st);
			if (s != 3) wr(`OFS_MODULO, 32'h0000_0009);
			if (s != 3) wr(`OFS_MODULO, 32'h0000_000F);
			if (s != 3) check(c1 == c2, 32'h1);
			if (s == 1) check(ch_out, 8'h5A);
			if (s == 2) check(ch_out, h);
			if (s > 0) check(st[7:0] != 8'h00, s == 3);
			halt_req <= 1'b0;
			cyc(6);
		end
	endtask

	// Sync sources and reload points; a reload point is judged by the reload flag, a sync load by the period that it leaves behind.
	task automatic t_reload;
		logic [31:0] d;
		logic [31:0] rs  [4] = '{32'h0000_0100, 32'h0000_0200, 32'h0000_0400, 32'h0000_0100};
		logic [31:0] md  [4] = '{32'h0000_0030, 32'h0000_0030, 32'h0000_0020, 32'h0000_0020};
		logic        exp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
		wr(`OFS_RELOAD_SEL, 32'h0000_0000);
		wr(`OFS_MODULO, 32'h0000_0007);
		wr(`OFS_HALF, 32'h0000_0003);
		wr(`OFS_CTRL, 32'h0000_0400);
		wr(`OFS_CTRL, 32'h0000_0440);
		wr(`OFS_CTRL, 32'h0000_0420);
		repeat (8) begin
			rd(`OFS_COUNT, d);
			check(d <= 32'h0000_0007, 32'h1);
			cyc(2);
		end
		for (int i = 0; i < 4; i++) begin
			wr(`OFS_RELOAD_SEL, rs[i]);
			wr(`OFS_CTRL, md[i]);
			wr(`OFS_STATUS, 32'h0000_0FFF);
			cyc(40);
			rd(`OFS_STATUS, d);
			check(d[`ST_RELOAD], exp[i]);
		end
		for (int k = 0; k < 3; k += 2) begin
			wr(`OFS_CTRL, 32'h0000_0080 << k);
			wr(`OFS_MODULO, 32'h0000_0005 - k);
			u_far.pulse_sync(k);
			cyc(4);
			wr(`OFS_CTRL, (32'h0000_0080 << k) | 32'h0000_0020);
			repeat (8) begin
				rd(`OFS_COUNT, d);
				check(d <= 32'h0000_0005 - k, 32'h1);
				cyc(2);
			end
		end
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		#200000;
		err_count++;
		give_verdict();
	end

	initial begin
		rst_n     = 1'b0;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 8'h00;
		pwdata    = 32'h0000_0000;
		halt_req  = 1'b0;
		err_count = 0;
		n_tests   = 0;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_regs();
		t_sync_load();
		t_trigger();
		t_irq();
		t_fault();
		t_halt();
		t_reload();
		give_verdict();
	end
endmodule
